/* core_storage_model.sv */
// Core storage as seen through relocation: answers instruction and operand reads.
// Assumes the bench preloads the words it needs; only six address bits decode.
`timescale 1ns/10ps
`default_nettype none
module core_storage_model
    import main_control_pkg::*;
(
    input  wire logic [ORIG_ADDR_W-1:0] fetch_addr,
    input  wire logic [ORIG_ADDR_W-1:0] operand_addr,
    output logic      [WORD_W-1:0]      fetch_word,
    output logic      [WORD_W-1:0]      operand_word
);
    // Small array keeps the run light; higher addresses alias onto it
    logic [WORD_W-1:0] mem [0:63];
    assign fetch_word   = mem[fetch_addr[5:0]];
    assign operand_word = mem[operand_addr[5:0]];
endmodule // core_storage_model
`default_nettype wire

/* main_control_pkg.sv */
// Constants, field layouts and carrier types for the main control register set.
// Assumes a single clock domain; shared by the top module and its register file.
package main_control_pkg;

    localparam int ADDR_W      = 15;
    localparam int WORD_W      = 24;
    localparam int CHAR_ADDR_W = 17;
    localparam int ORIG_ADDR_W = 18;
    localparam int STATE_W     = 3;
    localparam int FLAG_W      = 6;
    localparam int NUM_INDEX   = 3;
    localparam int RF_DEPTH    = 64;
    localparam int RF_AW       = 6;
    localparam int CHAR_W      = 6;
    localparam int PAR_W       = 4;

    localparam logic [14:0] P_RESET       = 15'h0000;
    localparam logic [14:0] P_STEP_NORMAL = 15'h0001;
    localparam logic [14:0] P_STEP_SKIP   = 15'h0002;
    localparam logic [23:0] WORD_RESET    = 24'h000000;
    localparam logic [14:0] INDEX_RESET   = 15'h0000;
    localparam logic [2:0]  STATE_RESET   = 3'h0;
    localparam logic [5:0]  FLAGS_RESET   = 6'h00;

    // Indirect replacement masks: low 18 bits, or bits 00-14 plus 17
    localparam logic [23:0] INDIRECT_MASK     = 24'h03ffff;
    localparam logic [23:0] INDIRECT_IDX_MASK = 24'h027fff;

    // Condition flag positions
    localparam int FLAG_BOUNDARY_JUMP = 0;
    localparam int FLAG_DESTRUCT_LOAD = 1;
    localparam int FLAG_OPERAND_RELOC = 2;
    localparam int FLAG_STATE_JUMP    = 3;
    localparam int FLAG_INT_ENABLE    = 4;
    localparam int FLAG_PROGRAM_STATE = 5;

    typedef enum logic [1:0] {EXIT_NEXT, EXIT_SKIP, EXIT_JUMP} exit_type;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [5:0]  addr;
        logic [23:0] wdata;
    } rf_req_type;

    typedef struct packed {
        logic        valid;
        logic        perr;
        logic [23:0] rdata;
    } rf_resp_type;

endpackage

/* main_control_registers.sv */
// Main control register set: program counter, instruction register with
// address modification, keyboard entry, index, state, channel and flag registers.
// Assumes an instruction decoder drives the strobes, one per cycle, synchronous to MCLK.
`timescale 1ns/10ps
`default_nettype none
module main_control_registers
    import main_control_pkg::*;
(
    input  wire logic                       MCLK,
    input  wire logic                       RST_N,
    input  wire logic                       FETCH_LOAD,
    input  wire logic [WORD_W-1:0]          FETCH_WORD,
    input  wire logic                       EXIT_DONE,
    input  var  exit_type                   EXIT_KIND,
    input  wire logic                       INDEX_APPLY,
    input  wire logic                       CHAR_ADDRESSED,
    input  wire logic [1:0]                 INDEX_DESIG,
    input  wire logic                       INDIRECT_LOAD,
    input  wire logic                       INDIRECT_IS_INDEX_OP,
    input  wire logic [WORD_W-1:0]          INDIRECT_WORD,
    input  wire logic                       INDEX_WRITE,
    input  wire logic [1:0]                 INDEX_WSEL,
    input  wire logic [ADDR_W-1:0]          INDEX_WDATA,
    input  wire logic                       EXEC_MODE,
    input  wire logic                       MONITOR_STATE,
    input  wire logic                       RUNNING,
    input  wire logic                       STATE_WRITE,
    input  wire logic                       STATE_SELECT_OPERAND,
    input  wire logic [STATE_W-1:0]         STATE_WDATA,
    input  wire logic                       CHAN_INSTR,
    input  wire logic [2:0]                 CHAN_FIELD_IN,
    input  wire logic                       ACC_TO_CHAN_INDEX,
    input  wire logic [2:0]                 ACC_LOW,
    input  wire logic                       KEY_ACTIVE,
    input  wire logic                       KEY_ENTER,
    input  wire logic [WORD_W-1:0]          KEY_VALUE,
    input  wire logic                       KEY_TRANSFER,
    input  wire logic                       KEYBOARD_ENTRY_CLEAR,
    input  wire logic                       FLAGS_ACCESS,
    input  wire logic [FLAG_W-1:0]          FLAGS_WDATA,
    input  wire logic [FLAG_W-1:0]          FLAGS_SET,
    input  wire logic [FLAG_W-1:0]          FLAGS_CLEAR,
    input  var  rf_req_type                 RF_REQ,
    input  wire logic                       PARITY_HALT_SW,
    input  wire logic                       PARITY_INT_SW,
    output var  logic [ADDR_W-1:0]          PROGRAM_ADDRESS,
    output var  logic [WORD_W-1:0]          INSTRUCTION,
    output var  logic [ORIG_ADDR_W-1:0]     FETCH_ADDRESS,
    output var  logic [ORIG_ADDR_W-1:0]     OPERAND_ADDRESS,
    output var  logic [NUM_INDEX-1:0][ADDR_W-1:0] INDEX_REGS,
    output var  logic [STATE_W-1:0]         INSTR_STATE,
    output var  logic [STATE_W-1:0]         OPERAND_STATE,
    output var  logic [2:0]                 CHAN_INDEX,
    output var  logic [2:0]                 CHAN_FIELD_OUT,
    output var  logic [FLAG_W-1:0]          CONDITION_FLAGS,
    output var  logic [FLAG_W-1:0]          EFFECTIVE_FLAGS,
    output var  logic [WORD_W-1:0]          KEY_ENTRY,
    output var  logic                       KEY_XFER_VALID,
    output var  logic [WORD_W-1:0]          KEY_XFER_DATA,
    output var  logic [WORD_W-1:0]          DISPLAY,
    output var  rf_resp_type                RF_RESP
);

    logic [ADDR_W-1:0]                  next_p;
    logic [WORD_W-1:0]                  next_instr;
    logic [ORIG_ADDR_W-1:0]             next_fetch;
    logic [ORIG_ADDR_W-1:0]             next_operand;
    logic [NUM_INDEX-1:0][ADDR_W-1:0]   next_index;
    logic [ADDR_W-1:0]                  index_val;
    logic [STATE_W-1:0]                 next_istate;
    logic [STATE_W-1:0]                 next_ostate;
    logic [2:0]                         next_cio;
    logic [2:0]                         next_chan_out;
    logic [FLAG_W-1:0]                  next_flags;
    logic [FLAG_W-1:0]                  next_eff;
    logic [WORD_W-1:0]                  next_entry;
    logic                               next_xfer_valid;
    logic [WORD_W-1:0]                  next_xfer_data;
    logic [WORD_W-1:0]                  next_display;
    logic                               monitor_ok;

    assign monitor_ok = EXEC_MODE && MONITOR_STATE;

    ////////////////////////////////////////////////////////////////////////////
    // Program counter and instruction register
    always_comb
    begin
        next_p = PROGRAM_ADDRESS;
        if (EXIT_DONE)
        begin
            case (EXIT_KIND)
                EXIT_NEXT: next_p = PROGRAM_ADDRESS + P_STEP_NORMAL;
                EXIT_SKIP: next_p = PROGRAM_ADDRESS + P_STEP_SKIP;
                EXIT_JUMP: next_p = INSTRUCTION[ADDR_W-1:0];
                default:   next_p = PROGRAM_ADDRESS;
            endcase
        end

        // Designator zero leaves the address untouched
        index_val = (INDEX_DESIG == 2'h0) ? INDEX_RESET : INDEX_REGS[INDEX_DESIG - 2'h1];

        // A new fetch wins over modification of the old word
        next_instr = INSTRUCTION;
        if (FETCH_LOAD)
        begin
            next_instr = FETCH_WORD;
        end
        else if (INDIRECT_LOAD)
        begin
            if (INDIRECT_IS_INDEX_OP)
            begin
                next_instr = (INSTRUCTION & ~INDIRECT_IDX_MASK) | (INDIRECT_WORD & INDIRECT_IDX_MASK);
            end
            else
            begin
                next_instr = (INSTRUCTION & ~INDIRECT_MASK) | (INDIRECT_WORD & INDIRECT_MASK);
            end
        end
        else if (INDEX_APPLY)
        begin
            if (CHAR_ADDRESSED)
            begin
                next_instr[CHAR_ADDR_W-1:0] = INSTRUCTION[CHAR_ADDR_W-1:0] + {2'h0, index_val};
            end
            else
            begin
                next_instr[ADDR_W-1:0] = INSTRUCTION[ADDR_W-1:0] + index_val;
            end
        end

        next_fetch   = {EXEC_MODE ? next_istate : STATE_RESET, next_p};
        next_operand = {EXEC_MODE ? next_ostate : STATE_RESET, next_instr[ADDR_W-1:0]};
    end

    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            PROGRAM_ADDRESS <= P_RESET;
            INSTRUCTION     <= WORD_RESET;
            FETCH_ADDRESS   <= '0;
            OPERAND_ADDRESS <= '0;
        end
        else
        begin
            PROGRAM_ADDRESS <= next_p;
            INSTRUCTION     <= next_instr;
            FETCH_ADDRESS   <= next_fetch;
            OPERAND_ADDRESS <= next_operand;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Index, state, channel index and condition flags
    always_comb
    begin
        next_index = INDEX_REGS;
        if (INDEX_WRITE && INDEX_WSEL != 2'h0)
        begin
            next_index[INDEX_WSEL - 2'h1] = INDEX_WDATA;
        end

        // Outside monitor a state write is dropped silently
        next_istate = INSTR_STATE;
        next_ostate = OPERAND_STATE;
        if (STATE_WRITE && monitor_ok)
        begin
            if (STATE_SELECT_OPERAND)
            begin
                next_ostate = STATE_WDATA;
            end
            else
            begin
                next_istate = STATE_WDATA;
            end
        end

        next_cio      = ACC_TO_CHAN_INDEX ? ACC_LOW : CHAN_INDEX;
        next_chan_out = CHAN_INSTR && monitor_ok ? (CHAN_FIELD_IN | CHAN_INDEX) : CHAN_FIELD_IN;

        // Selective set beats selective clear so no event is lost
        next_flags = FLAGS_ACCESS ? FLAGS_WDATA : CONDITION_FLAGS;
        next_flags = (next_flags & ~FLAGS_CLEAR) | FLAGS_SET;
        next_eff   = EXEC_MODE ? next_flags : (next_flags & FLAG_W'(1 << FLAG_INT_ENABLE));
    end

    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            INDEX_REGS      <= '0;
            INSTR_STATE     <= STATE_RESET;
            OPERAND_STATE   <= STATE_RESET;
            CHAN_INDEX      <= STATE_RESET;
            CHAN_FIELD_OUT  <= STATE_RESET;
            CONDITION_FLAGS <= FLAGS_RESET;
            EFFECTIVE_FLAGS <= FLAGS_RESET;
        end
        else
        begin
            INDEX_REGS      <= next_index;
            INSTR_STATE     <= next_istate;
            OPERAND_STATE   <= next_ostate;
            CHAN_INDEX      <= next_cio;
            CHAN_FIELD_OUT  <= next_chan_out;
            CONDITION_FLAGS <= next_flags;
            EFFECTIVE_FLAGS <= next_eff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Keyboard entry register and shared display
    always_comb
    begin
        next_entry = KEY_ENTRY;
        if (KEYBOARD_ENTRY_CLEAR)
        begin
            next_entry = WORD_RESET;
        end
        else if (KEY_ENTER)
        begin
            next_entry = KEY_VALUE;
        end
        next_xfer_valid = KEY_TRANSFER;
        next_xfer_data  = KEY_TRANSFER ? KEY_ENTRY : KEY_XFER_DATA;

        // While running with the keyboard idle the display follows the program counter
        if (KEY_ACTIVE)
        begin
            next_display = next_entry;
        end
        else if (!RUNNING)
        begin
            next_display = next_instr;
        end
        else
        begin
            next_display = {9'h000, next_p};
        end
    end

    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            KEY_ENTRY      <= WORD_RESET;
            KEY_XFER_VALID <= 1'b0;
            KEY_XFER_DATA  <= WORD_RESET;
            DISPLAY        <= WORD_RESET;
        end
        else
        begin
            KEY_ENTRY      <= next_entry;
            KEY_XFER_VALID <= next_xfer_valid;
            KEY_XFER_DATA  <= next_xfer_data;
            DISPLAY        <= next_display;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register file with parity
    register_file_parity #(
        .DEPTH    (RF_DEPTH)
    ) u_file (
        .clk      (MCLK),
        .rst_n    (RST_N),
        .req      (RF_REQ),
        .check_en (PARITY_HALT_SW || PARITY_INT_SW),
        .resp     (RF_RESP)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    p_step_a: assert property (EXIT_DONE && EXIT_KIND == EXIT_NEXT && !FETCH_LOAD
        |=> PROGRAM_ADDRESS == $past(PROGRAM_ADDRESS) + P_STEP_NORMAL) else $error("counter step wrong");
    p_skip_a: assert property (EXIT_DONE && EXIT_KIND == EXIT_SKIP
        |=> PROGRAM_ADDRESS == $past(PROGRAM_ADDRESS) + P_STEP_SKIP) else $error("skip step wrong");
    p_jump_a: assert property (EXIT_DONE && EXIT_KIND == EXIT_JUMP
        |=> PROGRAM_ADDRESS == $past(INSTRUCTION[ADDR_W-1:0])) else $error("jump target wrong");
    instr_hold_a: assert property (!FETCH_LOAD && !INDIRECT_LOAD && !INDEX_APPLY
        |=> $stable(INSTRUCTION)) else $error("instruction changed unasked");
    index_zero_a: assert property (INDEX_APPLY && INDEX_DESIG == 2'h0 && !FETCH_LOAD && !INDIRECT_LOAD
        |=> $stable(INSTRUCTION)) else $error("designator zero modified address");
    ind_high_a: assert property (INDIRECT_LOAD && !FETCH_LOAD
        |=> INSTRUCTION[WORD_W-1:ORIG_ADDR_W] == $past(INSTRUCTION[WORD_W-1:ORIG_ADDR_W]))
        else $error("indirect touched high bits");
    state_lock_a: assert property (STATE_WRITE && !(EXEC_MODE && MONITOR_STATE)
        |=> $stable(INSTR_STATE) && $stable(OPERAND_STATE)) else $error("state written outside monitor");
    fetch_form_a: assert property (##1 FETCH_ADDRESS[ADDR_W-1:0] == PROGRAM_ADDRESS
        && ($past(EXEC_MODE) || FETCH_ADDRESS[ORIG_ADDR_W-1:ADDR_W] == STATE_RESET))
        else $error("fetch address malformed");
    chan_or_a: assert property (CHAN_INSTR && EXEC_MODE && MONITOR_STATE
        |=> CHAN_FIELD_OUT == ($past(CHAN_FIELD_IN) | $past(CHAN_INDEX))) else $error("channel index not merged");
    flag_set_a: assert property (FLAGS_SET[FLAG_INT_ENABLE]
        |=> CONDITION_FLAGS[FLAG_INT_ENABLE] && EFFECTIVE_FLAGS[FLAG_INT_ENABLE]) else $error("flag set lost");
    flag_mask_a: assert property (!EXEC_MODE
        |=> (EFFECTIVE_FLAGS & ~FLAG_W'(1 << FLAG_INT_ENABLE)) == '0) else $error("flag leaked outside executive");
    key_clear_a: assert property (KEYBOARD_ENTRY_CLEAR |=> KEY_ENTRY == WORD_RESET) else $error("entry not cleared");

    skip_exit_c: cover property (EXIT_DONE && EXIT_KIND == EXIT_SKIP);
    indirect_idx_c: cover property (INDIRECT_LOAD && INDIRECT_IS_INDEX_OP);
    monitor_chan_c: cover property (CHAN_INSTR && EXEC_MODE && MONITOR_STATE && CHAN_INDEX != 3'h0);
    parity_err_c: cover property (RF_RESP.perr);

endmodule // main_control_registers
`default_nettype wire

/* main_control_registers_tb.sv */
// Self-checking bench for the main control register set.
// Assumes strobes are taken at MCLK rising edges and outputs settle one cycle later.
`timescale 1ns/10ps
`default_nettype none
module main_control_registers_tb;
    import main_control_pkg::*;
`define CHK(a,b) begin checks++; if ((a)!==(b)) begin errors++; $display("mismatch %0t %h %h",$time,a,b); end end
    ////////////////////////////////////////////////////////////////////////////////
    logic             MCLK, RST_N, FETCH_LOAD, EXIT_DONE, INDEX_APPLY, CHAR_ADDRESSED;
    logic             INDIRECT_LOAD, INDIRECT_IS_INDEX_OP, INDEX_WRITE, EXEC_MODE, MONITOR_STATE;
    logic             RUNNING, STATE_WRITE, STATE_SELECT_OPERAND, CHAN_INSTR, ACC_TO_CHAN_INDEX;
    logic             KEY_ACTIVE, KEY_ENTER, KEY_TRANSFER, KEYBOARD_ENTRY_CLEAR, FLAGS_ACCESS;
    logic             PARITY_HALT_SW, PARITY_INT_SW, KEY_XFER_VALID;
    logic [1:0]       INDEX_DESIG, INDEX_WSEL;
    logic [2:0]       STATE_WDATA, CHAN_FIELD_IN, ACC_LOW, INSTR_STATE, OPERAND_STATE, CHAN_INDEX;
    logic [2:0]       CHAN_FIELD_OUT;
    logic [5:0]       FLAGS_WDATA, FLAGS_SET, FLAGS_CLEAR, CONDITION_FLAGS, EFFECTIVE_FLAGS;
    logic [14:0]      INDEX_WDATA, PROGRAM_ADDRESS;
    logic [17:0]      FETCH_ADDRESS, OPERAND_ADDRESS;
    logic [23:0]      FETCH_WORD, INDIRECT_WORD, KEY_VALUE, INSTRUCTION, KEY_ENTRY;
    logic [23:0]      KEY_XFER_DATA, DISPLAY, e;
    logic [2:0][14:0] INDEX_REGS;
    exit_type         EXIT_KIND;
    rf_req_type       RF_REQ;
    rf_resp_type      RF_RESP;
    int               errors, checks;
    ////////////////////////////////////////////////////////////////////////////////
    main_control_registers uut (.MCLK, .RST_N, .FETCH_LOAD, .FETCH_WORD, .EXIT_DONE, .EXIT_KIND,
        .INDEX_APPLY, .CHAR_ADDRESSED, .INDEX_DESIG, .INDIRECT_LOAD, .INDIRECT_IS_INDEX_OP,
        .INDIRECT_WORD, .INDEX_WRITE, .INDEX_WSEL, .INDEX_WDATA, .EXEC_MODE, .MONITOR_STATE,
        .RUNNING, .STATE_WRITE, .STATE_SELECT_OPERAND, .STATE_WDATA, .CHAN_INSTR, .CHAN_FIELD_IN,
        .ACC_TO_CHAN_INDEX, .ACC_LOW, .KEY_ACTIVE, .KEY_ENTER, .KEY_VALUE, .KEY_TRANSFER,
        .KEYBOARD_ENTRY_CLEAR, .FLAGS_ACCESS, .FLAGS_WDATA, .FLAGS_SET, .FLAGS_CLEAR, .RF_REQ,
        .PARITY_HALT_SW, .PARITY_INT_SW, .PROGRAM_ADDRESS, .INSTRUCTION, .FETCH_ADDRESS,
        .OPERAND_ADDRESS, .INDEX_REGS, .INSTR_STATE, .OPERAND_STATE, .CHAN_INDEX, .CHAN_FIELD_OUT,
        .CONDITION_FLAGS, .EFFECTIVE_FLAGS, .KEY_ENTRY, .KEY_XFER_VALID, .KEY_XFER_DATA,
        .DISPLAY, .RF_RESP);
    core_storage_model store (.fetch_addr(FETCH_ADDRESS), .operand_addr(OPERAND_ADDRESS),
        .fetch_word(FETCH_WORD), .operand_word(INDIRECT_WORD));
    always #5 MCLK = ~MCLK;
    ////////////////////////////////////////////////////////////////////////////////
    task step;
        @(negedge MCLK);
    endtask
    task end_of_test;
        if (errors == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // A step, a skip, a fetch, a jump to 7fff, then a wrap past the top of the counter
    task t_counter;
        store.mem[3] = 24'h127fff;
        `CHK(PROGRAM_ADDRESS, 15'h0000)
        EXIT_DONE = 1; EXIT_KIND = EXIT_NEXT; step; `CHK(PROGRAM_ADDRESS, 15'h0001)
        EXIT_KIND = EXIT_SKIP; step; EXIT_DONE = 0; `CHK(PROGRAM_ADDRESS, 15'h0003)
        step; `CHK(FETCH_ADDRESS, 18'h00003)
        FETCH_LOAD = 1; step; FETCH_LOAD = 0; step; `CHK(INSTRUCTION, 24'h127fff)
        EXIT_DONE = 1; EXIT_KIND = EXIT_JUMP; step; `CHK(PROGRAM_ADDRESS, 15'h7fff)
        EXIT_KIND = EXIT_NEXT; step; EXIT_DONE = 0; `CHK(PROGRAM_ADDRESS, 15'h0000)
    endtask
    // Word add drops the carry out of bit 14; character add carries it into bit 15
    task t_index;
        INDEX_WRITE = 1; INDEX_WSEL = 2; INDEX_WDATA = 15'h7ff0; step;
        INDEX_WSEL = 0; INDEX_WDATA = 15'h1234; step; INDEX_WRITE = 0;
        `CHK(INDEX_REGS, {15'h0000, 15'h7ff0, 15'h0000})
        INDEX_APPLY = 1; INDEX_DESIG = 2; step; `CHK(INSTRUCTION, 24'h127fef)
        CHAR_ADDRESSED = 1; step; `CHK(INSTRUCTION, 24'h12ffdf)
        INDEX_DESIG = 0; step; INDEX_APPLY = 0; CHAR_ADDRESSED = 0; `CHK(INSTRUCTION, 24'h12ffdf)
    endtask
    task t_indirect;
        e = 24'h12ffdf; step; `CHK(OPERAND_ADDRESS, {3'h0, e[14:0]})
        store.mem[e[5:0]] = 24'hfedcba; INDIRECT_LOAD = 1; step; INDIRECT_LOAD = 0;
        e = (e & 24'hfc0000) | (24'hfedcba & 24'h03ffff); `CHK(INSTRUCTION, e)
        step; store.mem[e[5:0]] = 24'h0f0f0f; INDIRECT_IS_INDEX_OP = 1; INDIRECT_LOAD = 1; step;
        INDIRECT_LOAD = 0; INDIRECT_IS_INDEX_OP = 0;
        e = (e & 24'hfd8000) | (24'h0f0f0f & 24'h027fff); `CHK(INSTRUCTION, e)
    endtask
    // A write outside monitor state must be dropped
    task t_state;
        EXEC_MODE = 1; STATE_WRITE = 1; STATE_WDATA = 3'h5; step; `CHK(INSTR_STATE, 3'h0)
        MONITOR_STATE = 1; step; `CHK(INSTR_STATE, 3'h5)
        STATE_SELECT_OPERAND = 1; STATE_WDATA = 3'h6; step; STATE_WRITE = 0; step;
        `CHK(OPERAND_STATE, 3'h6)
        `CHK(FETCH_ADDRESS, 18'h28000)
        `CHK(OPERAND_ADDRESS, {3'h6, e[14:0]})
    endtask
    task t_chan;
        ACC_TO_CHAN_INDEX = 1; ACC_LOW = 3'h5; step; ACC_TO_CHAN_INDEX = 0; `CHK(CHAN_INDEX, 3'h5)
        CHAN_INSTR = 1; CHAN_FIELD_IN = 3'h2; step; `CHK(CHAN_FIELD_OUT, 3'h7)
        MONITOR_STATE = 0; step; `CHK(CHAN_FIELD_OUT, 3'h2)
        MONITOR_STATE = 1; CHAN_INSTR = 0; step; `CHK(CHAN_FIELD_OUT, 3'h2)
    endtask
    task t_flags;
        FLAGS_ACCESS = 1; FLAGS_WDATA = 6'h3f; step; FLAGS_ACCESS = 0; `CHK(CONDITION_FLAGS, 6'h3f)
        FLAGS_CLEAR = 6'h21; step; `CHK(CONDITION_FLAGS, 6'h1e)
        FLAGS_SET = 6'h01; FLAGS_CLEAR = 6'h01; step; `CHK(CONDITION_FLAGS, 6'h1f)
        FLAGS_SET = 0; FLAGS_CLEAR = 0; step; `CHK(EFFECTIVE_FLAGS, 6'h1f)
        EXEC_MODE = 0; step; `CHK(EFFECTIVE_FLAGS, 6'h10)
    endtask
    task t_key;
        step; `CHK(DISPLAY, e)
        KEY_ACTIVE = 1; KEY_ENTER = 1; KEY_VALUE = 24'habcdef; step; KEY_ENTER = 0; step;
        `CHK(KEY_ENTRY, 24'habcdef)
        `CHK(DISPLAY, 24'habcdef)
        KEY_TRANSFER = 1; step; KEY_TRANSFER = 0; `CHK({KEY_XFER_VALID, KEY_XFER_DATA}, 25'h1abcdef)
        KEYBOARD_ENTRY_CLEAR = 1; KEY_ENTER = 1; step; KEYBOARD_ENTRY_CLEAR = 0; KEY_ENTER = 0;
        `CHK({KEY_XFER_VALID, KEY_XFER_DATA}, 25'h0abcdef)
        `CHK(KEY_ENTRY, 24'h000000)
        KEY_ACTIVE = 0; RUNNING = 1; step; RUNNING = 0;
        `CHK(DISPLAY, 24'h000000)
    endtask
    // Lowest and highest entries, each under a different check switch
    task t_rf;
        for (int i = 0; i < 2; i++)
        begin
            {PARITY_HALT_SW, PARITY_INT_SW} = i ? 2'b01 : 2'b10;
            RF_REQ = '{wr: 1'b1, rd: 1'b0, addr: i ? 6'h3f : 6'h00, wdata: i ? 24'hffffff : 24'h000001};
            step; {RF_REQ.wr, RF_REQ.rd} = 2'b01; step;
            `CHK(RF_RESP, {2'b10, (i ? 24'hffffff : 24'h000001)})
        end
        RF_REQ = '0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        MCLK = 0; RST_N = 0; errors = 0; checks = 0; e = 0; EXIT_KIND = EXIT_NEXT; RF_REQ = '0;
        {FETCH_LOAD, EXIT_DONE, INDEX_APPLY, CHAR_ADDRESSED, INDIRECT_LOAD, INDIRECT_IS_INDEX_OP,
         INDEX_WRITE, EXEC_MODE, MONITOR_STATE, RUNNING, STATE_WRITE, STATE_SELECT_OPERAND, CHAN_INSTR,
         ACC_TO_CHAN_INDEX, KEY_ACTIVE, KEY_ENTER, KEY_TRANSFER, KEYBOARD_ENTRY_CLEAR, FLAGS_ACCESS,
         PARITY_HALT_SW, PARITY_INT_SW, INDEX_DESIG, INDEX_WSEL, STATE_WDATA, CHAN_FIELD_IN, ACC_LOW,
         FLAGS_WDATA, FLAGS_SET, FLAGS_CLEAR, INDEX_WDATA, KEY_VALUE} = '0;
        repeat (8) @(posedge MCLK);
        step; RST_N = 1;
        t_counter; t_index; t_indirect; t_state; t_chan; t_flags; t_key; t_rf;
        end_of_test;
    end
    // A hang counts as a mismatch
    initial
    begin
        #100000; errors++; end_of_test;
    end
endmodule // main_control_registers_tb
`default_nettype wire

/* register_file_parity.sv */
// 64-entry register file, 24 data bits plus one odd parity bit per character.
// Assumes requests are single-cycle strobes from the main control block.
`timescale 1ns/10ps
`default_nettype none
module register_file_parity
    import main_control_pkg::*;
#(
    parameter int DEPTH = RF_DEPTH
)(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  var  rf_req_type  req,
    input  wire logic        check_en,
    output var  rf_resp_type resp
);

    logic [PAR_W+WORD_W-1:0] mem [DEPTH];
    logic [PAR_W-1:0]        wpar;
    logic [PAR_W-1:0]        rpar;
    logic [PAR_W+WORD_W-1:0] rword;
    rf_resp_type             next_resp;

    ////////////////////////////////////////////////////////////////////////////
    // Parity per character, generated on write and recomputed on read
    genvar g;
    generate
        for (g = 0; g < PAR_W; g++)
        begin : g_par
            assign wpar[g] = ~^req.wdata[g*CHAR_W +: CHAR_W];
            assign rpar[g] = ~^rword[g*CHAR_W +: CHAR_W];
        end
    endgenerate

    assign rword = mem[req.addr];

    always_comb
    begin
        next_resp.valid = req.rd;
        next_resp.rdata = rword[WORD_W-1:0];
        // Checking is gated by the console switches
        next_resp.perr  = req.rd && check_en && (rpar != rword[PAR_W+WORD_W-1:WORD_W]);
    end

    // Storage has no reset: a real flip-flop matrix powers up unknown
    always_ff @(posedge clk)
    begin
        if (req.wr)
        begin
            mem[req.addr] <= {wpar, req.wdata};
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            resp <= '0;
        end
        else
        begin
            resp <= next_resp;
        end
    end

    rf_read_latency_a: assert property (@(posedge clk) disable iff (!rst_n)
        req.rd |=> resp.valid) else $error("register file read not answered");
    rf_check_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        !$past(check_en) |-> !resp.perr) else $error("parity error with checking off");

endmodule // register_file_parity
`default_nettype wire
